/* reset_ctrl_pkg.sv */
// Constants shared by the reset mode and software reset controller
package reset_ctrl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 250;
  localparam int SW_RESET_TIME_NS = 250000;
  localparam int SW_RESET_CYCLES = (SW_RESET_TIME_NS * CLOCK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] CONFIG_OFFSET = 4'h8;

  // ----------------------------------------------------------------
  // Command words and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] SW_RESET_CMD = 16'hFE00;
  localparam logic [7:0] FIFO_MODE_PREFIX = 8'hC1;
  localparam logic [7:0] AFC_CTRL_PREFIX = 8'hB0;
  localparam int RESET_MODE_BIT = 0;
  localparam int AFC_ENABLE_BIT = 0;
  localparam int STAT_IN_RESET = 0;
  localparam int STAT_SENSITIVE = 1;
  localparam int STAT_AFC_EN = 2;
  localparam int STAT_AFC_LSB = 8;
  localparam int AFC_WIDTH = 5;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic SENSITIVE_RESET = 1'b1;
  localparam logic AFC_ENABLE_RESET = 1'b1;
  localparam logic [7:0] FIFO_CFG_RESET = 8'h00;

  typedef enum logic {RUN, HOLD} reset_state_type;
endpackage

/* reset_mode_control.sv */
// Reset mode selection, reset hold sequencing and command decode
// Function
// - Reset on power-on, glitch or software command
// - Ignore commands while power-on reset lasts
// - Sensitive and normal modes; sensitive after reset
// - Normal mode disables glitch detection
// - Config command bit 0 selects normal mode
// - FE00h resets only in sensitive mode
// - Software reset held shorter, about 0.25ms
// - Every reset restores all configuration defaults
// - Status reports measured AFC offset
`timescale 1ns/100ps
`default_nettype none
module reset_mode_control #(
  parameter int HOLD_CYCLES = reset_ctrl_pkg::SW_RESET_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic powerOnDetect,
  input wire logic glitchDetect,
  input wire logic [reset_ctrl_pkg::AFC_WIDTH-1:0] afcOffset,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic chipReset,
  output logic sensitiveMode,
  output logic afcEnable
);
  import reset_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // A one-cycle hold could not keep reset up for the two cycles that follow a command
  if (HOLD_CYCLES < 2) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least two");
  end

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_q;
  logic rstSync_n;
  logic [1:0] pinRaw;
  wire logic [1:0] pinLevel;
  assign rstSync_n = rstPipe_q[1];
  assign pinRaw = {glitchDetect, powerOnDetect};

  // Two-stage release keeps the deassertion clean of metastability
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end

  // Comparator outputs are asynchronous; stage one feeds stage two only
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    // Each pin owns its own level flop, so no vector has two writers
    always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
      end else if (clockEnable) begin
        s1_q <= pinRaw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          level_q <= s3_q;
        end
      end
    end
    assign pinLevel[i] = level_q;
  end
  wire porLevel = pinLevel[0];
  wire glitchLevel = pinLevel[1];

  // ----------------------------------------------------------------
  // Bus slave and command decode
  // ----------------------------------------------------------------
  logic waitrequest_q, waitrequest_d;
  logic [31:0] readdata_q, readdata_d;
  logic sensitive_q, sensitive_d;
  logic afcEn_q, afcEn_d;
  logic [7:0] fifoCfg_q, fifoCfg_d;
  logic [AFC_WIDTH-1:0] afcOffset_q;
  logic chipReset_q, chipReset_d;
  reset_state_type state_q, state_d;
  logic [31:0] holdCnt_q, holdCnt_d;
  logic cmdWrite;
  logic swReset;
  logic [15:0] cmdWord;

  assign cmdWord = writedata[15:0];
  // Commands are dropped while the chip is held in reset
  assign cmdWrite = write && !waitrequest_q && address == CMD_OFFSET
                    && (&byteenable[1:0]) && !chipReset_q;
  assign swReset = cmdWrite && cmdWord == SW_RESET_CMD && sensitive_q;

  // One wait cycle, then a single ready cycle per request
  always_comb begin
    waitrequest_d = !((read || write) && waitrequest_q);
    readdata_d = readdata_q;
    if (read && waitrequest_q) begin
      case (address)
        STATUS_OFFSET: begin
          readdata_d = 32'h0;
          readdata_d[STAT_IN_RESET] = chipReset_q;
          readdata_d[STAT_SENSITIVE] = sensitive_q;
          readdata_d[STAT_AFC_EN] = afcEn_q;
          readdata_d[STAT_AFC_LSB +: AFC_WIDTH] = afcOffset_q;
        end
        CONFIG_OFFSET: begin
          readdata_d = {24'h0, fifoCfg_q};
        end
        default: begin
          readdata_d = 32'h0;
        end
      endcase
    end
  end

  // Configuration state; any reset forces defaults
  always_comb begin
    sensitive_d = sensitive_q;
    afcEn_d = afcEn_q;
    fifoCfg_d = fifoCfg_q;
    if (chipReset_q) begin
      sensitive_d = SENSITIVE_RESET;
      afcEn_d = AFC_ENABLE_RESET;
      fifoCfg_d = FIFO_CFG_RESET;
    end else if (cmdWrite && cmdWord[15:8] == FIFO_MODE_PREFIX) begin
      fifoCfg_d = cmdWord[7:0];
      // Only leaves sensitive mode; a reset is the way back
      if (cmdWord[RESET_MODE_BIT]) begin
        sensitive_d = 1'b0;
      end
    end else if (cmdWrite && cmdWord[15:8] == AFC_CTRL_PREFIX) begin
      afcEn_d = cmdWord[AFC_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  logic glitchCause;
  assign glitchCause = glitchLevel && sensitive_q;

  // Power-on holds for as long as the comparator says; the hold count
  // then runs from its release, so a ramp is never cut short
  always_comb begin
    state_d = state_q;
    holdCnt_d = holdCnt_q;
    if (porLevel || glitchCause || swReset) begin
      state_d = HOLD;
      holdCnt_d = 32'(HOLD_CYCLES - 1);
    end else if (state_q == HOLD) begin
      if (holdCnt_q == 32'h0) begin
        state_d = RUN;
      end else begin
        holdCnt_d = holdCnt_q - 32'h1;
      end
    end
    chipReset_d = (state_d == HOLD);
  end

  // Registers of bus, configuration and sequencer
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0;
      sensitive_q <= SENSITIVE_RESET;
      afcEn_q <= AFC_ENABLE_RESET;
      fifoCfg_q <= FIFO_CFG_RESET;
      afcOffset_q <= '0;
      state_q <= HOLD;
      holdCnt_q <= 32'(HOLD_CYCLES - 1);
      chipReset_q <= 1'b1;
    end else if (clockEnable) begin
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
      sensitive_q <= sensitive_d;
      afcEn_q <= afcEn_d;
      fifoCfg_q <= fifoCfg_d;
      afcOffset_q <= afcOffset;
      state_q <= state_d;
      holdCnt_q <= holdCnt_d;
      chipReset_q <= chipReset_d;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign chipReset = chipReset_q;
  assign sensitiveMode = sensitive_q;
  assign afcEnable = afcEn_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_n);

  chk_bus_ready: assert property (
    clockEnable && (read || write) && waitrequest_q |=> !waitrequest_q)
    else $error("request not answered after one wait cycle");
  chk_bus_release: assert property (clockEnable && !waitrequest_q |=> waitrequest_q)
    else $error("ready held longer than one cycle");
  chk_por_holds: assert property (clockEnable && porLevel |=> chipReset_q)
    else $error("power-on level did not hold reset");
  chk_sw_reset: assert property (clockEnable && swReset |=> chipReset_q[*2])
    else $error("software reset command did not reset");
  chk_sw_normal: assert property (
    clockEnable && cmdWrite && cmdWord == SW_RESET_CMD && !sensitive_q
    && !porLevel && state_q == RUN |=> !chipReset_q)
    else $error("software reset acted in normal mode");
  chk_glitch_gated: assert property (
    clockEnable && glitchLevel && !sensitive_q && !porLevel && !swReset
    && state_q == RUN |=> !chipReset_q)
    else $error("glitch reset while in normal mode");
  chk_reset_default: assert property (
    clockEnable && chipReset_q |=> sensitive_q && afcEn_q && fifoCfg_q == FIFO_CFG_RESET)
    else $error("configuration not restored by reset");
  chk_normal_select: assert property (
    clockEnable && cmdWrite && cmdWord[15:8] == FIFO_MODE_PREFIX
    && cmdWord[RESET_MODE_BIT] |=> !sensitive_q)
    else $error("mode bit did not select normal mode");
  chk_cmd_ignored: assert property (
    clockEnable && chipReset_q && write && !waitrequest_q && cmdWord == SW_RESET_CMD
    && !porLevel && !glitchCause && holdCnt_q != 32'h0
    |=> holdCnt_q == $past(holdCnt_q) - 32'h1)
    else $error("command accepted during reset");
  chk_afc_status: assert property (
    clockEnable && read && waitrequest_q && address == STATUS_OFFSET
    |=> readdata_q[STAT_AFC_LSB +: AFC_WIDTH] == $past(afcOffset_q))
    else $error("status did not carry AFC offset");

  cov_sw_reset: cover property (swReset ##1 chipReset_q ##[1:1000] !chipReset_q);
  cov_normal_mode: cover property ($fell(sensitive_q));
  cov_glitch: cover property (glitchCause && !chipReset_q);
  cov_status_read: cover property (read && !waitrequest_q && address == STATUS_OFFSET);
endmodule // reset_mode_control
`default_nettype wire

/* host_model.sv */
// Bus master model of the host microcontroller
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output var logic [3:0] address,
  output var logic read,
  output var logic write,
  output var logic [31:0] writedata,
  output var logic [3:0] byteenable
);
  // ----------------------------------------
  // Idle bus from time zero
  // ----------------------------------------
  initial begin
    address <= 4'h0;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'h0;
    byteenable <= 4'hF;
  end

  // One command word per write; held until waitrequest drops
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    writedata <= ~writedata; // Stale data must not look valid
  endtask

  // Read data taken at the edge that sees waitrequest low
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the reset mode controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  import reset_ctrl_pkg::*;
  localparam int SIM_HOLD = 8; // Short hold keeps the run brief
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clockEnable = 1'b1;
  logic powerOnDetect = 1'b0;
  logic glitchDetect = 1'b0;
  logic [AFC_WIDTH-1:0] afcOffset = '0;
  logic [3:0] address;
  logic read, write, waitrequest, chipReset, sensitiveMode, afcEnable;
  logic [31:0] writedata, readdata, rdata;
  logic [3:0] byteenable;
  int badCount = 0;
  int samplesChecked = 0;
  int n;

  always #2 clock = ~clock;

  host_model host (.clock(clock), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));

  reset_mode_control #(.HOLD_CYCLES(SIM_HOLD)) uut (.clock(clock), .reset_n(reset_n),
    .clockEnable(clockEnable), .powerOnDetect(powerOnDetect), .glitchDetect(glitchDetect),
    .afcOffset(afcOffset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .chipReset(chipReset), .sensitiveMode(sensitiveMode),
    .afcEnable(afcEnable));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Counts held cycles; bounded so a stuck reset cannot hang
  task waitRelease();
    n = 0;
    while (chipReset !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask

  task glitch();
    @(posedge clock);
    glitchDetect <= 1'b1;
    repeat (3) @(posedge clock);
    glitchDetect <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task testDefaults();
    waitRelease();
    host.rd(STATUS_OFFSET, rdata);
    check(32'(rdata[2:0]), 32'h6);
    host.rd(4'hC, rdata);
    check(rdata, 32'h0);
    $display("test defaults done");
  endtask

  task testSwReset();
    host.wr(CMD_OFFSET, 16'hC142);
    @(posedge clock);
    check(32'(sensitiveMode), 32'h1);
    host.rd(CONFIG_OFFSET, rdata);
    check(rdata, 32'h42);
    host.wr(CMD_OFFSET, 16'hB000);
    @(posedge clock);
    check(32'(afcEnable), 32'h0);
    host.wr(CMD_OFFSET, SW_RESET_CMD);
    @(posedge clock);
    waitRelease();
    check(32'(n >= SIM_HOLD - 1 && n <= SIM_HOLD + 1), 32'h1);
    host.rd(CONFIG_OFFSET, rdata);
    check(rdata, 32'h0);
    check(32'(afcEnable), 32'h1);
    $display("test software reset done");
  endtask

  task testAfcRead();
    afcOffset <= 5'h15;
    host.wr(CMD_OFFSET, 16'hB000);
    host.rd(STATUS_OFFSET, rdata);
    check(32'(rdata[12:8]), 32'h15);
    check(32'(rdata[2]), 32'h0);
    $display("test offset read done");
  endtask

  task testGlitch();
    glitch();
    check(32'(chipReset), 32'h1);
    waitRelease();
    $display("test glitch done");
  endtask

  task testNormal();
    host.wr(CMD_OFFSET, 16'hC101);
    @(posedge clock);
    check(32'(sensitiveMode), 32'h0);
    glitch();
    check(32'(chipReset), 32'h0);
    host.wr(CMD_OFFSET, SW_RESET_CMD);
    repeat (4) @(posedge clock);
    check(32'(chipReset), 32'h0);
    powerOnDetect <= 1'b1;
    repeat (8) @(posedge clock);
    check(32'(chipReset), 32'h1);
    host.wr(CMD_OFFSET, 16'hC101);
    powerOnDetect <= 1'b0;
    // Software reset sent during the hold must not restart the count
    repeat (6) @(posedge clock);
    host.wr(CMD_OFFSET, SW_RESET_CMD);
    waitRelease();
    check(32'(n < SIM_HOLD), 32'h1);
    check(32'(sensitiveMode), 32'h1);
    $display("test normal mode done");
  endtask

  // Clock enable low must freeze the hold counter in mid-reset
  task testFreeze();
    host.wr(CMD_OFFSET, SW_RESET_CMD);
    clockEnable <= 1'b0;
    repeat (20) @(posedge clock);
    check(32'(chipReset), 32'h1);
    clockEnable <= 1'b1;
    waitRelease();
    check(32'(n >= SIM_HOLD - 1 && n <= SIM_HOLD + 1), 32'h1);
    $display("test clock enable done");
  endtask

  task printVerdict();
    $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well beyond the full sequence
  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    printVerdict();
  end

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    testDefaults();
    testSwReset();
    testAfcRead();
    testGlitch();
    testNormal();
    testFreeze();
    printVerdict();
  end
endmodule // tb
`default_nettype wire
